// >>> hw/gpt_pkg.sv
// Package for the 32-bit general-purpose timer: register map, control
// field positions, reset values and time-format limits.
// Assumes a 32-bit classic Wishbone slave port and one system clock.
package gpt_pkg;

    // Register byte addresses on the Wishbone bus
    localparam logic [31:0] GPT_ADR_RELOAD = 32'hFFFF0380;
    localparam logic [31:0] GPT_ADR_COUNT = 32'hFFFF0384;
    localparam logic [31:0] GPT_ADR_CTRL = 32'hFFFF0388;
    localparam logic [31:0] GPT_ADR_CLEAR = 32'hFFFF038C;
    localparam logic [31:0] GPT_ADR_CAPTURE = 32'hFFFF0390;
    localparam logic [31:0] GPT_ADR_IRQ_STS = 32'hFFFF0394;
    localparam logic [31:0] GPT_ADR_IRQ_MASK = 32'hFFFF0398;

    // Control register field positions
    localparam int GPT_CTRL_W = 18;
    localparam int GPT_PSC_LSB = 0;
    localparam int GPT_FMT_LSB = 4;
    localparam int GPT_MODE_BIT = 6;
    localparam int GPT_EN_BIT = 7;
    localparam int GPT_UP_BIT = 8;
    localparam int GPT_CLK_LSB = 9;
    localparam int GPT_EVT_LSB = 12;
    localparam int GPT_CAP_EN_BIT = 17;

    // Clock source select codes
    localparam logic [2:0] GPT_CLK_OSC = 3'h0;
    localparam logic [2:0] GPT_CLK_CORE = 3'h1;
    localparam logic [2:0] GPT_CLK_PLL_A = 3'h2;
    localparam logic [2:0] GPT_CLK_PLL_B = 3'h3;

    // Count format codes
    localparam logic [1:0] GPT_FMT_HMS23 = 2'h2;
    localparam logic [1:0] GPT_FMT_HMS255 = 2'h3;

    // Interrupt status and mask bit positions
    localparam int GPT_IRQ_W = 2;
    localparam int GPT_IRQ_OVF = 0;
    localparam int GPT_IRQ_CAP = 1;

    // Reset values
    localparam logic [31:0] GPT_RST_RELOAD = 32'h00000000;
    localparam logic [31:0] GPT_RST_COUNT = 32'h00000000;
    localparam logic [31:0] GPT_RST_CAPTURE = 32'h00000000;
    localparam logic [GPT_CTRL_W-1:0] GPT_RST_CTRL = 18'h00000;

    // Time-format field limits
    localparam logic [7:0] GPT_HUND_MAX = 8'h63;
    localparam logic [7:0] GPT_SEC_MAX = 8'h3B;
    localparam logic [7:0] GPT_HR_MAX23 = 8'h17;
    localparam logic [7:0] GPT_HR_MAX255 = 8'hFF;

endpackage

// >>> hw/gpt_timer.sv
// General-purpose 32-bit timer with prescaler, time-of-day format,
// event capture and a Wishbone classic register slave.
// Assumes irq_src_i and low_power_i come from logic on clk_sys; the
// oscillator and PLL tick inputs are pins and are synchronised here.
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ns

module gpt_timer
    import gpt_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic osc_32k_i,
    input wire logic pll_undivided_clock_i,
    input wire logic low_power_i,
    input wire logic [31:0] irq_src_i,
    output logic timer_irq_o,
    output logic irq_o
);

    typedef struct packed {
        logic [31:0] reload;
        logic [31:0] count;
        logic [GPT_CTRL_W-1:0] ctrl;
        logic [31:0] capture;
        logic [14:0] psc_cnt;
        logic tmr_pend;
        logic [GPT_IRQ_W-1:0] sts;
        logic [GPT_IRQ_W-1:0] mask;
        logic irq;
        logic ack;
        logic [31:0] rdata;
        logic osc_s1;
        logic osc_s2;
        logic osc_d;
        logic pll_s1;
        logic pll_s2;
        logic pll_d;
        logic evt_d;
    } gpt_state_s;

    localparam gpt_state_s GPT_RST_STATE = '{
        reload: GPT_RST_RELOAD,
        count: GPT_RST_COUNT,
        ctrl: GPT_RST_CTRL,
        capture: GPT_RST_CAPTURE,
        default: '0
    };

    gpt_state_s st_r;
    gpt_state_s st_nxt;

    // Combinational helpers, also watched by the assertions
    logic req;
    logic wr;
    logic rd;
    logic clr_wr;
    logic src_tick;
    logic tick;
    logic ovf;
    logic cap_evt;
    logic sel_evt;
    logic [14:0] psc_lim;
    logic [32:0] step;
    logic [31:0] ctrl_wm;
    logic [31:0] mask_wm;

    // Byte-lane merge for Wishbone writes
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // One step of the hh:mm:ss:cc counter; bit 32 flags the wrap past the range end
    function automatic logic [32:0] hms_step(input logic [31:0] v, input logic up, input logic [7:0] hmax);
        logic [7:0] h;
        logic [7:0] m;
        logic [7:0] s;
        logic [7:0] c;
        logic wrap;
        h = v[31:24];
        m = v[23:16];
        s = v[15:8];
        c = v[7:0];
        wrap = 1'b0;
        if (up) begin
            // Out-of-range loaded fields roll over as if at their maximum
            if (c < GPT_HUND_MAX) begin
                c = c + 8'h01;
            end else begin
                c = 8'h00;
                if (s < GPT_SEC_MAX) begin
                    s = s + 8'h01;
                end else begin
                    s = 8'h00;
                    if (m < GPT_SEC_MAX) begin
                        m = m + 8'h01;
                    end else begin
                        m = 8'h00;
                        if (h < hmax) begin
                            h = h + 8'h01;
                        end else begin
                            h = 8'h00;
                            wrap = 1'b1;
                        end
                    end
                end
            end
        end else begin
            if (c != 8'h00) begin
                c = c - 8'h01;
            end else begin
                c = GPT_HUND_MAX;
                if (s != 8'h00) begin
                    s = s - 8'h01;
                end else begin
                    s = GPT_SEC_MAX;
                    if (m != 8'h00) begin
                        m = m - 8'h01;
                    end else begin
                        m = GPT_SEC_MAX;
                        if (h != 8'h00) begin
                            h = h - 8'h01;
                        end else begin
                            h = hmax;
                            wrap = 1'b1;
                        end
                    end
                end
            end
        end
        return {wrap, h, m, s, c};
    endfunction

    // Whole next-state computation
    always_comb begin
        st_nxt = st_r;
        clr_wr = 1'b0;
        src_tick = 1'b0;
        tick = 1'b0;
        ovf = 1'b0;
        step = 33'h000000000;

        // Pin synchronisers; only the second stage and its delayed copy feed logic
        st_nxt.osc_s1 = osc_32k_i;
        st_nxt.osc_s2 = st_r.osc_s1;
        st_nxt.osc_d = st_r.osc_s2;
        st_nxt.pll_s1 = pll_undivided_clock_i;
        st_nxt.pll_s2 = st_r.pll_s1;
        st_nxt.pll_d = st_r.pll_s2;

        // Wishbone: one request per ack, ack drops the cycle after it is given
        req = wb_cyc_i & wb_stb_i & ~st_r.ack;
        wr = req & wb_we_i;
        rd = req & ~wb_we_i;
        st_nxt.ack = req;
        st_nxt.rdata = 32'h00000000;
        ctrl_wm = lane_merge(32'(st_r.ctrl), wb_dat_i, wb_sel_i);
        mask_wm = lane_merge(32'(st_r.mask), wb_dat_i, wb_sel_i);

        // Register writes; count and capture ignore writes
        if (wr) begin
            case (wb_adr_i)
                GPT_ADR_RELOAD: st_nxt.reload = lane_merge(st_r.reload, wb_dat_i, wb_sel_i);
                GPT_ADR_CTRL: st_nxt.ctrl = ctrl_wm[GPT_CTRL_W-1:0];
                GPT_ADR_CLEAR: clr_wr = 1'b1;
                GPT_ADR_IRQ_MASK: st_nxt.mask = mask_wm[GPT_IRQ_W-1:0];
                default: ;
            endcase
        end

        // Register reads; unmapped and write-only addresses read as zero
        if (rd) begin
            case (wb_adr_i)
                GPT_ADR_RELOAD: st_nxt.rdata = st_r.reload;
                GPT_ADR_COUNT: st_nxt.rdata = st_r.count;
                GPT_ADR_CTRL: st_nxt.rdata = 32'(st_r.ctrl);
                GPT_ADR_CAPTURE: st_nxt.rdata = st_r.capture;
                GPT_ADR_IRQ_STS: st_nxt.rdata = 32'(st_r.sts);
                GPT_ADR_IRQ_MASK: st_nxt.rdata = 32'(st_r.mask);
                default: st_nxt.rdata = 32'h00000000;
            endcase
        end

        // Source select; core and PLL sources halt in low-power mode, the oscillator does not
        case (st_r.ctrl[GPT_CLK_LSB +: 3])
            GPT_CLK_OSC: src_tick = st_r.osc_s2 & ~st_r.osc_d;
            GPT_CLK_CORE: src_tick = ~low_power_i;
            GPT_CLK_PLL_A: src_tick = st_r.pll_s2 & ~st_r.pll_d & ~low_power_i;
            GPT_CLK_PLL_B: src_tick = st_r.pll_s2 & ~st_r.pll_d & ~low_power_i;
            default: src_tick = 1'b0;
        endcase

        // Prescaler divides by two to the power of the field, held clear while disabled
        psc_lim = 15'((32'h00000001 << st_r.ctrl[GPT_PSC_LSB +: 4]) - 32'h00000001);
        if (!st_r.ctrl[GPT_EN_BIT]) begin
            st_nxt.psc_cnt = 15'h0000;
        end else if (src_tick) begin
            if (st_r.psc_cnt >= psc_lim) begin
                st_nxt.psc_cnt = 15'h0000;
                tick = 1'b1;
            end else begin
                st_nxt.psc_cnt = st_r.psc_cnt + 15'h0001;
            end
        end

        // Counter step in the selected format; reserved format 01 counts in binary
        case (st_r.ctrl[GPT_FMT_LSB +: 2])
            GPT_FMT_HMS23: step = hms_step(st_r.count, st_r.ctrl[GPT_UP_BIT], GPT_HR_MAX23);
            GPT_FMT_HMS255: step = hms_step(st_r.count, st_r.ctrl[GPT_UP_BIT], GPT_HR_MAX255);
            default: begin
                if (st_r.ctrl[GPT_UP_BIT]) begin
                    step = {1'b0, st_r.count} + 33'h000000001;
                end else begin
                    step = {st_r.count == 32'h00000000, st_r.count - 32'h00000001};
                end
            end
        endcase

        // Clear-register reload beats a tick, but a wrapping tick still counts as an overflow
        ovf = tick & step[32];
        if (clr_wr) begin
            st_nxt.count = st_r.reload;
        end else if (tick) begin
            if (step[32] && st_r.ctrl[GPT_MODE_BIT]) begin
                st_nxt.count = st_r.reload;
            end else begin
                st_nxt.count = step[31:0];
            end
        end

        // Capture on the first assertion of the selected source
        sel_evt = irq_src_i[st_r.ctrl[GPT_EVT_LSB +: 5]];
        st_nxt.evt_d = sel_evt;
        cap_evt = st_r.ctrl[GPT_CAP_EN_BIT] & sel_evt & ~st_r.evt_d;
        if (cap_evt) begin
            st_nxt.capture = st_r.count;
        end

        // Timer interrupt: a new overflow beats a clear in the same cycle
        if (clr_wr) begin
            st_nxt.tmr_pend = 1'b0;
        end
        if (ovf) begin
            st_nxt.tmr_pend = 1'b1;
        end

        // Sticky status, cleared by reading it; events arriving during the read survive
        if (rd && wb_adr_i == GPT_ADR_IRQ_STS) begin
            st_nxt.sts = '0;
        end
        st_nxt.sts[GPT_IRQ_OVF] = st_nxt.sts[GPT_IRQ_OVF] | ovf;
        st_nxt.sts[GPT_IRQ_CAP] = st_nxt.sts[GPT_IRQ_CAP] | cap_evt;
        st_nxt.irq = |(st_nxt.sts & st_nxt.mask);
    end

    // State register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= GPT_RST_STATE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Every output straight from the state register
    assign wb_dat_o = st_r.rdata;
    assign wb_ack_o = st_r.ack;
    assign timer_irq_o = st_r.tmr_pend;
    assign irq_o = st_r.irq;

    // Checks on the timer behaviour
    property p_ack_pulse;
        @(posedge clk_sys) disable iff (!rst_n)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("Ack held longer than one cycle");

    property p_dir_step;
        @(posedge clk_sys) disable iff (!rst_n)
        tick && !clr_wr && st_r.ctrl[GPT_FMT_LSB +: 2] == 2'h0 && !ovf
        |=> st_r.count == ($past(st_r.ctrl[GPT_UP_BIT]) ? $past(st_r.count) + 32'h00000001
                                                       : $past(st_r.count) - 32'h00000001);
    endproperty
    a_dir_step: assert property (p_dir_step) else $error("Binary count moved the wrong way");

    property p_core_src;
        @(posedge clk_sys) disable iff (!rst_n)
        st_r.ctrl[GPT_CLK_LSB +: 3] == GPT_CLK_CORE |-> src_tick == !low_power_i;
    endproperty
    a_core_src: assert property (p_core_src) else $error("Core clock source not ticking");

    property p_psc_div;
        @(posedge clk_sys) disable iff (!rst_n)
        tick |-> st_r.psc_cnt == psc_lim && src_tick;
    endproperty
    a_psc_div: assert property (p_psc_div) else $error("Prescaler ticked early");

    property p_disabled_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        !st_r.ctrl[GPT_EN_BIT] && !clr_wr |=> $stable(st_r.count);
    endproperty
    a_disabled_hold: assert property (p_disabled_hold) else $error("Count moved while disabled");

    property p_periodic_reload;
        @(posedge clk_sys) disable iff (!rst_n)
        ovf && st_r.ctrl[GPT_MODE_BIT] |=> st_r.count == $past(st_r.reload);
    endproperty
    a_periodic_reload: assert property (p_periodic_reload) else $error("Periodic end missed reload");

    property p_hms_wrap;
        @(posedge clk_sys) disable iff (!rst_n)
        tick && !clr_wr && st_r.ctrl[GPT_FMT_LSB +: 2] == GPT_FMT_HMS23 && !st_r.ctrl[GPT_UP_BIT]
        && !st_r.ctrl[GPT_MODE_BIT] && st_r.count == 32'h00000000 |=> st_r.count == 32'h173B3B63;
    endproperty
    a_hms_wrap: assert property (p_hms_wrap) else $error("Time format underflow wrong");

    property p_clear_reload;
        @(posedge clk_sys) disable iff (!rst_n)
        clr_wr |=> st_r.count == $past(st_r.reload) ##1 wb_ack_o == 1'b0;
    endproperty
    a_clear_reload: assert property (p_clear_reload) else $error("Clear write did not reload");

    property p_clear_pend;
        @(posedge clk_sys) disable iff (!rst_n)
        clr_wr && !ovf |=> !timer_irq_o;
    endproperty
    a_clear_pend: assert property (p_clear_pend) else $error("Clear write left interrupt pending");

    property p_cap_off;
        @(posedge clk_sys) disable iff (!rst_n)
        !st_r.ctrl[GPT_CAP_EN_BIT] |=> $stable(st_r.capture);
    endproperty
    a_cap_off: assert property (p_cap_off) else $error("Capture while disabled");

    property p_cap_src;
        @(posedge clk_sys) disable iff (!rst_n)
        cap_evt |-> irq_src_i[st_r.ctrl[GPT_EVT_LSB +: 5]] && !st_r.evt_d;
    endproperty
    a_cap_src: assert property (p_cap_src) else $error("Capture from wrong source");

    property p_cap_value;
        @(posedge clk_sys) disable iff (!rst_n)
        cap_evt |=> st_r.capture == $past(st_r.count);
    endproperty
    a_cap_value: assert property (p_cap_value) else $error("Captured value wrong");

    property p_ovf_pend;
        @(posedge clk_sys) disable iff (!rst_n)
        ovf |=> timer_irq_o && st_r.sts[GPT_IRQ_OVF];
    endproperty
    a_ovf_pend: assert property (p_ovf_pend) else $error("Overflow did not raise interrupt");

    property p_free_wrap;
        @(posedge clk_sys) disable iff (!rst_n)
        ovf && !clr_wr && !st_r.ctrl[GPT_MODE_BIT] && st_r.ctrl[GPT_FMT_LSB +: 2] == 2'h0
        |=> st_r.count == ($past(st_r.ctrl[GPT_UP_BIT]) ? 32'h00000000 : 32'hFFFFFFFF);
    endproperty
    a_free_wrap: assert property (p_free_wrap) else $error("Free-running wrap wrong");

endmodule // gpt_timer

// >>> tb/test_gpt_timer.sv
// Self-checking testbench for the general-purpose timer: register map,
// count sequences, clock sources, time format, capture and interrupts.
// Assumes the gpt_pkg register map and a 100 MHz clk_sys.
`timescale 1ns/1ns

module test_gpt_timer
    import gpt_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] wb_adr_i = 32'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic wb_we_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic osc_32k_i = 1'b0;
    logic pll_undivided_clock_i = 1'b0;
    logic low_power_i = 1'b0;
    logic [31:0] irq_src_i = 32'h0;
    logic timer_irq_o;
    logic irq_o;
    int mismatches = 0;
    int n_checks = 0;
    int cyc = 0;

    gpt_timer u_gpt_timer (.clk_sys(clk_sys), .rst_n(rst_n), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .osc_32k_i(osc_32k_i), .pll_undivided_clock_i(pll_undivided_clock_i),
        .low_power_i(low_power_i), .irq_src_i(irq_src_i), .timer_irq_o(timer_irq_o), .irq_o(irq_o));

    // 10 ns clock
    always #5 clk_sys = ~clk_sys;

    // Slow source pins: oscillator period 40 cycles, PLL period 8 cycles
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        osc_32k_i <= (cyc % 40) < 20;
        pll_undivided_clock_i <= cyc[2];
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk1(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
        n_checks++;
        if (g < lo || g > hi) begin
            mismatches++;
            $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask

    // Classic single cycle; request held until ack is sampled high
    task automatic wb(input logic we, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_sys);
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_we_i <= we;
        wb_sel_i <= 4'hF;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        if (n >= 16) begin
            mismatches++;
            $display("mismatch wb_ack expected 1 seen %b", wb_ack_o);
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] q);
        wb(1'b0, a, 32'h0, q);
    endtask

    // Next expected count, binary or hours:minutes:seconds:hundredths
    function automatic logic [31:0] nxt(logic [31:0] v, bit up, bit per, logic [1:0] fmt, logic [31:0] rl);
        logic [7:0] hm;
        logic [31:0] top;
        hm = (fmt == GPT_FMT_HMS255) ? GPT_HR_MAX255 : GPT_HR_MAX23;
        top = fmt[1] ? {hm, GPT_SEC_MAX, GPT_SEC_MAX, GPT_HUND_MAX} : 32'hFFFFFFFF;
        if (up && v == top) return per ? rl : 32'h0;
        if (!up && v == 32'h0) return per ? rl : top;
        if (!fmt[1]) return up ? v + 32'h1 : v - 32'h1;
        if (up) begin
            if (v[7:0] != GPT_HUND_MAX) return v + 32'h1;
            if (v[15:8] != GPT_SEC_MAX) return {v[31:16], v[15:8] + 8'h1, 8'h0};
            if (v[23:16] != GPT_SEC_MAX) return {v[31:24], v[23:16] + 8'h1, 16'h0};
            return {v[31:24] + 8'h1, 24'h0};
        end
        if (v[7:0] != 8'h0) return v - 32'h1;
        if (v[15:8] != 8'h0) return {v[31:16], v[15:8] - 8'h1, GPT_HUND_MAX};
        if (v[23:16] != 8'h0) return {v[31:24], v[23:16] - 8'h1, GPT_SEC_MAX, GPT_HUND_MAX};
        return {v[31:24] - 8'h1, GPT_SEC_MAX, GPT_SEC_MAX, GPT_HUND_MAX};
    endfunction

    // Reload, start, then follow the count by polling; pc is the tick spacing
    task automatic run(input logic [2:0] cs, input logic [3:0] ps, input bit up, input bit per,
                       input logic [1:0] fmt, input logic [31:0] rl, input int steps, input int pc);
        logic [31:0] e, r, x;
        int t0, n, lo, hi;
        bit wrp;
        wr(GPT_ADR_CTRL, 32'h0);
        wr(GPT_ADR_RELOAD, rl);
        wr(GPT_ADR_CLEAR, $urandom);
        chk1("timer_irq_clr", 1'b0, timer_irq_o);
        rd(GPT_ADR_COUNT, r);
        chk32("count_reload", rl, r);
        wr(GPT_ADR_CTRL, {14'h0, 1'b0, 5'h0, cs, up, 1'b1, per, fmt, ps});
        e = rl;
        wrp = 0;
        // First step timed from the enable; pin sources start at an unknown phase
        t0 = cyc;
        lo = (cs == GPT_CLK_CORE) ? pc - 5 : 1;
        hi = (cs == GPT_CLK_CORE) ? pc + 5 : 2 * pc;
        repeat (steps) begin
            n = 0;
            do begin
                rd(GPT_ADR_COUNT, r);
                n++;
            end while (r === e && n < pc + 20);
            x = nxt(e, up, per, fmt, rl);
            wrp |= up ? (x < e) : (x > e);
            chk32("count_step", x, r);
            chk_rng("tick_gap", lo, hi, cyc - t0);
            t0 = cyc;
            lo = pc - 5;
            hi = pc + 5;
            e = x;
        end
        @(posedge clk_sys);
        chk1("timer_irq", wrp, timer_irq_o);
        wr(GPT_ADR_CTRL, 32'h0);
    endtask

    // Source that must give no ticks: count stays at the reload value
    task automatic still(input logic [2:0] cs, input logic lp);
        logic [31:0] rl, r;
        low_power_i <= lp;
        rl = $urandom;
        wr(GPT_ADR_CTRL, 32'h0);
        wr(GPT_ADR_RELOAD, rl);
        wr(GPT_ADR_CLEAR, 32'h0);
        wr(GPT_ADR_CTRL, {20'h0, cs, 9'h080});
        repeat (64) @(posedge clk_sys);
        rd(GPT_ADR_COUNT, r);
        chk32("count_still", rl, r);
        wr(GPT_ADR_CTRL, 32'h0);
        low_power_i <= 1'b0;
    endtask

    task automatic pulse(input int k);
        @(posedge clk_sys);
        irq_src_i[k] <= 1'b1;
        repeat (3) @(posedge clk_sys);
        irq_src_i <= 32'h0;
    endtask

    // Watchdog well beyond the expected run length
    initial begin
        repeat (90000) @(posedge clk_sys);
        mismatches++;
        $display("mismatch watchdog expected done seen timeout");
        end_sim();
    end

    initial begin
        logic [31:0] adr [8];
        logic [31:0] r, d;
        int k, p;
        void'($urandom(98952));
        adr = '{GPT_ADR_RELOAD, GPT_ADR_COUNT, GPT_ADR_CTRL, GPT_ADR_CLEAR, GPT_ADR_CAPTURE,
                GPT_ADR_IRQ_STS, GPT_ADR_IRQ_MASK, 32'hFFFF039C};
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        // Reset values, access kinds, unmapped place
        foreach (adr[i]) begin
            rd(adr[i], r);
            chk32("reset_value", 32'h0, r);
        end
        d = $urandom;
        wr(GPT_ADR_RELOAD, d);
        rd(GPT_ADR_RELOAD, r);
        chk32("reload_rw", d, r);
        d = $urandom & 32'h0003FF7F;
        wr(GPT_ADR_CTRL, d);
        rd(GPT_ADR_CTRL, r);
        chk32("ctrl_rw", d, r);
        wr(GPT_ADR_CTRL, 32'h0);
        for (int i = 1; i < 8; i++) begin
            if (i == 2 || i == 6) continue;
            wr(adr[i], $urandom);
            rd(adr[i], r);
            chk32("ro_wo_read", 32'h0, r);
        end
        // Count sequences across sources, modes and formats
        run(GPT_CLK_CORE, 4'h4, 0, 0, 2'h0, 32'h2, 5, 16);
        p = $urandom_range(8, 5);
        run(GPT_CLK_CORE, p[3:0], 0, 1, 2'h0, 32'h1, 4, 1 << p);
        run(GPT_CLK_CORE, 4'h4, 1, 0, 2'h0, 32'hFFFFFFFE, 4, 16);
        run(GPT_CLK_CORE, 4'h4, 1, 1, 2'h0, 32'hFFFFFFFD, 5, 16);
        low_power_i <= 1'b1;
        run(GPT_CLK_OSC, 4'h0, 0, 0, 2'h0, $urandom_range(2, 0), 4, 40);
        low_power_i <= 1'b0;
        run(GPT_CLK_PLL_A, 4'h2, 1, 0, 2'h0, $urandom, 3, 32);
        run(GPT_CLK_PLL_B, 4'h2, 0, 0, 2'h0, $urandom | 32'h10, 3, 32);
        run(GPT_CLK_CORE, 4'h4, 0, 0, GPT_FMT_HMS23, 32'h1, 4, 16);
        run(GPT_CLK_CORE, 4'h4, 1, 0, GPT_FMT_HMS255, 32'hFF3B3B62, 3, 16);
        run(GPT_CLK_CORE, 4'h4, 1, 1, GPT_FMT_HMS23, 32'h00003B62, 3, 16);
        run(GPT_CLK_CORE, 4'h4, 0, 0, 2'h1, 32'h00000100, 3, 16);
        run(GPT_CLK_CORE, 4'hF, 0, 0, 2'h0, 32'h00000005, 1, 32768);
        still(GPT_CLK_CORE, 1'b1);
        still(3'h4 | 3'($urandom_range(3, 0)), 1'b0);
        // Capture with the timer stopped so the count is known
        rd(GPT_ADR_IRQ_STS, r);
        chk1("sts_overflow", 1'b1, r[GPT_IRQ_OVF]);
        k = $urandom_range(31, 0);
        d = $urandom;
        wr(GPT_ADR_IRQ_MASK, 32'h2);
        wr(GPT_ADR_RELOAD, d);
        wr(GPT_ADR_CLEAR, 32'h0);
        wr(GPT_ADR_CTRL, {14'h0, 1'b1, 5'(k), 12'h200});
        pulse((k + 1) % 32);
        rd(GPT_ADR_CAPTURE, r);
        chk32("capture_other_src", 32'h0, r);
        pulse(k);
        rd(GPT_ADR_CAPTURE, r);
        chk32("capture_value", d, r);
        chk1("irq_cap", 1'b1, irq_o);
        wr(GPT_ADR_IRQ_MASK, 32'h0);
        @(posedge clk_sys);
        chk1("irq_masked", 1'b0, irq_o);
        rd(GPT_ADR_IRQ_STS, r);
        chk32("sts_capture", 32'h2, r);
        rd(GPT_ADR_IRQ_STS, r);
        chk32("sts_cleared", 32'h0, r);
        // Capture disabled: a new edge leaves the old value
        wr(GPT_ADR_RELOAD, ~d);
        wr(GPT_ADR_CLEAR, 32'h0);
        wr(GPT_ADR_CTRL, {14'h0, 1'b0, 5'(k), 12'h200});
        pulse(k);
        rd(GPT_ADR_CAPTURE, r);
        chk32("capture_disabled", d, r);
        chk1("timer_irq_idle", 1'b0, timer_irq_o);
        end_sim();
    end
endmodule // test_gpt_timer
